// ### rtl/usart_rx_map.svh
// register offsets, field positions, reset values and word bit counts of the receiver
`ifndef USART_RX_MAP_SVH
`define USART_RX_MAP_SVH
`define OFS_RX_STATUS 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_TX_STATUS 8'h08
`define OFS_BAUD_DIV 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_ENABLE 8'h14
`define OFS_IRQ_CLEAR 8'h18
`define RS_SERIAL_PORT_ENABLE 7
`define RS_RX9 6
`define RS_SINGLE_RECEIVE_ENABLE 5
`define RS_CONTINUOUS_RECEIVE_ENABLE 4
`define RS_FRAMING_ERROR_FLAG 2
`define RS_OVERRUN_ERROR_FLAG 1
`define RS_RECEIVED_NINTH_BIT 0
`define TS_CLOCK_SOURCE_SELECT 7
`define TS_TX9 6
`define TS_TRANSMIT_ENABLE 5
`define TS_SYNC 4
`define TS_HIGH_SPEED_BAUD_SELECT 2
`define TS_TRANSMIT_SHIFT_EMPTY 1
`define TS_TRANSMIT_NINTH_BIT 0
`define IRQ_RX_DONE 0
`define IRQ_OVERRUN 1
`define RST_RX_STATUS 8'h00
`define RST_RX_DATA 8'h00
`define RST_TX_STATUS 8'h02
`define RST_BAUD_DIV 8'h00
`define RST_IRQ 2'h0
`define BITS_SHORT 4'h8
`define BITS_LONG 4'h9
`endif

// ### rtl/usart_rx_pkg.sv
// types shared by the synchronous master receiver
package usart_rx_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW = 3'b100
	} rx_state_t;
	typedef logic [7:0] byte_t;
endpackage

// ### rtl/usart_sync_master_receive.sv
// synchronous master receive path with an ahb-lite register slave
`timescale 1ns/1ps
`include "usart_rx_map.svh"
module usart_sync_master_receive
	import usart_rx_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic sclk_out,
	output logic sclk_oe_n,
	input wire logic sclk_in,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe_n,
	output logic irq
);
	logic serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, overrun_error_flag_reg, received_ninth_bit_reg;
	logic clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg, high_speed_baud_select_reg, transmit_ninth_bit_reg;
	byte_t rx_data_reg, baud_reg;
	logic [1:0] irq_stat_reg, irq_en_reg;
	logic full_reg;
	rx_state_t state_reg;
	logic [8:0] div_cnt_reg, shift_reg;
	logic [3:0] bit_cnt_reg;
	logic sclk_reg;
	logic [2:0] din_sync_reg;
	logic din_reg;
	logic wr_pend_reg, rd_wait_reg;
	logic [7:0] addr_reg;
	logic [31:0] hrdata_reg;
	logic addr_ok, wr_now, rd_now, data_rd, master_mode, start_ok;
	logic half_hit, last_bit, word_done, overrun_evt, continuous_receive_enable_clear;
	logic [3:0] word_bits;
	// reset words held as constants so single bits can be selected from them
	localparam byte_t rst_rx_status = `RST_RX_STATUS;
	localparam byte_t rst_tx_status = `RST_TX_STATUS;

	function automatic logic [8:0] half_limit(input byte_t div);
		// half a bit period is 2*(div+1) system clocks
		half_limit = {div, 1'b1};
	endfunction

	function automatic byte_t word_byte(input logic nine, input logic [8:0] sh);
		word_byte = nine ? sh[7:0] : sh[8:1];
	endfunction

	assign hresp = 1'b0;
	assign hreadyout = ~rd_wait_reg;
	assign hrdata = hrdata_reg;
	assign addr_ok = hsel & hready & htrans[1];
	assign wr_now = wr_pend_reg;
	assign rd_now = addr_ok & ~hwrite;
	assign data_rd = rd_wait_reg & (addr_reg == `OFS_RX_DATA);
	assign continuous_receive_enable_clear = wr_now & (addr_reg == `OFS_RX_STATUS) & continuous_receive_enable_reg & ~hwdata[`RS_CONTINUOUS_RECEIVE_ENABLE];
	assign master_mode = serial_port_enable_reg & sync_reg & clock_source_select_reg;
	assign start_ok = master_mode & (single_receive_enable_reg | continuous_receive_enable_reg);
	assign word_bits = rx9_reg ? `BITS_LONG : `BITS_SHORT;
	assign half_hit = (div_cnt_reg == half_limit(baud_reg));
	assign last_bit = (bit_cnt_reg == word_bits);
	assign word_done = (state_reg == ST_LOW) & half_hit & last_bit & start_ok;
	assign overrun_evt = word_done & full_reg & ~data_rd;

	assign sclk_out = sclk_reg;
	assign sclk_oe_n = ~master_mode;
	assign data_out = 1'b0;
	assign data_oe_n = 1'b1;
	assign irq = |(irq_stat_reg & irq_en_reg);

	// bus address phase capture; reads take one wait state so hrdata comes from a flop
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			addr_reg <= 8'h00;
		end
		else
		begin
			wr_pend_reg <= addr_ok & hwrite & (hsize == 3'h2);
			rd_wait_reg <= rd_now;
			if (addr_ok)
				addr_reg <= {haddr[7:2], 2'h0};
		end
	end

	// read mux; unmapped and write-only offsets read zero
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			hrdata_reg <= 32'h0000_0000;
		else if (rd_wait_reg)
		begin
			case (addr_reg)
				`OFS_RX_STATUS: hrdata_reg <= {24'h0, serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg,
					1'b0, 1'b0, overrun_error_flag_reg, received_ninth_bit_reg};
				`OFS_RX_DATA: hrdata_reg <= {24'h0, rx_data_reg};
				`OFS_TX_STATUS: hrdata_reg <= {24'h0, clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg,
					1'b0, high_speed_baud_select_reg, 1'b1, transmit_ninth_bit_reg};
				`OFS_BAUD_DIV: hrdata_reg <= {24'h0, baud_reg};
				`OFS_IRQ_STATUS: hrdata_reg <= {30'h0, irq_stat_reg};
				`OFS_IRQ_ENABLE: hrdata_reg <= {30'h0, irq_en_reg};
				default: hrdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			{serial_port_enable_reg, rx9_reg, continuous_receive_enable_reg} <= {rst_rx_status[`RS_SERIAL_PORT_ENABLE],
				rst_rx_status[`RS_RX9], rst_rx_status[`RS_CONTINUOUS_RECEIVE_ENABLE]};
			{clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg} <= rst_tx_status[7:4];
			{high_speed_baud_select_reg, transmit_ninth_bit_reg} <= {rst_tx_status[`TS_HIGH_SPEED_BAUD_SELECT], rst_tx_status[`TS_TRANSMIT_NINTH_BIT]};
			baud_reg <= `RST_BAUD_DIV;
			irq_en_reg <= `RST_IRQ;
		end
		else if (wr_now)
		begin
			case (addr_reg)
				`OFS_RX_STATUS:
				begin
					serial_port_enable_reg <= hwdata[`RS_SERIAL_PORT_ENABLE];
					rx9_reg <= hwdata[`RS_RX9];
					continuous_receive_enable_reg <= hwdata[`RS_CONTINUOUS_RECEIVE_ENABLE];
				end
				`OFS_TX_STATUS:
				begin
					clock_source_select_reg <= hwdata[`TS_CLOCK_SOURCE_SELECT];
					tx9_reg <= hwdata[`TS_TX9];
					transmit_enable_reg <= hwdata[`TS_TRANSMIT_ENABLE];
					sync_reg <= hwdata[`TS_SYNC];
					// high-speed select has no effect on the clocked link
					high_speed_baud_select_reg <= hwdata[`TS_HIGH_SPEED_BAUD_SELECT];
					transmit_ninth_bit_reg <= hwdata[`TS_TRANSMIT_NINTH_BIT];
				end
				`OFS_BAUD_DIV: baud_reg <= hwdata[7:0];
				`OFS_IRQ_ENABLE: irq_en_reg <= hwdata[1:0];
				default:
				begin
				end
			endcase
		end
	end

	// single enable: software write wins over the hardware clear after one word
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			single_receive_enable_reg <= rst_rx_status[`RS_SINGLE_RECEIVE_ENABLE];
		else if (wr_now & (addr_reg == `OFS_RX_STATUS))
			single_receive_enable_reg <= hwdata[`RS_SINGLE_RECEIVE_ENABLE];
		else if (word_done & ~continuous_receive_enable_reg)
			single_receive_enable_reg <= 1'b0;
	end

	// overrun flag: a new overrun beats the clear from dropping continuous enable
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			overrun_error_flag_reg <= rst_rx_status[`RS_OVERRUN_ERROR_FLAG];
		else if (overrun_evt)
			overrun_error_flag_reg <= 1'b1;
		else if (continuous_receive_enable_clear)
			overrun_error_flag_reg <= 1'b0;
	end

	// received word holding; an unread word is kept and the new one dropped on overrun
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_data_reg <= `RST_RX_DATA;
			received_ninth_bit_reg <= rst_rx_status[`RS_RECEIVED_NINTH_BIT];
			full_reg <= 1'b0;
		end
		else if (word_done & ~overrun_evt)
		begin
			rx_data_reg <= word_byte(rx9_reg, shift_reg);
			received_ninth_bit_reg <= rx9_reg & shift_reg[8];
			full_reg <= 1'b1;
		end
		else if (data_rd)
			full_reg <= 1'b0;
	end

	// sticky interrupt status; an event in the clearing cycle stays set
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			irq_stat_reg <= `RST_IRQ;
		else
		begin
			irq_stat_reg[`IRQ_RX_DONE] <= word_done | (irq_stat_reg[`IRQ_RX_DONE] &
				~(wr_now & (addr_reg == `OFS_IRQ_CLEAR) & hwdata[`IRQ_RX_DONE]));
			irq_stat_reg[`IRQ_OVERRUN] <= overrun_evt | (irq_stat_reg[`IRQ_OVERRUN] &
				~(wr_now & (addr_reg == `OFS_IRQ_CLEAR) & hwdata[`IRQ_OVERRUN]));
		end
	end

	// data pin filter: a level counts once the second and third stages agree
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			din_sync_reg <= 3'h0;
			din_reg <= 1'b0;
		end
		else
		begin
			din_sync_reg <= {din_sync_reg[1:0], data_in};
			if (din_sync_reg[1] == din_sync_reg[2])
				din_reg <= din_sync_reg[2];
		end
	end

	// clock generator and shifter; the filter delays data by four cycles, so the
	// partner must set data up that long before the falling edge
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_reg <= ST_IDLE;
			div_cnt_reg <= 9'h000;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 9'h000;
			sclk_reg <= 1'b0;
		end
		else if (!start_ok)
		begin
			state_reg <= ST_IDLE;
			div_cnt_reg <= 9'h000;
			bit_cnt_reg <= 4'h0;
			sclk_reg <= 1'b0;
		end
		else
		begin
			div_cnt_reg <= half_hit ? 9'h000 : div_cnt_reg + 9'h001;
			case (state_reg)
				ST_IDLE:
				begin
					state_reg <= ST_HIGH;
					div_cnt_reg <= 9'h000;
					bit_cnt_reg <= 4'h0;
					sclk_reg <= 1'b1;
				end
				ST_HIGH:
				begin
					if (half_hit)
					begin
						sclk_reg <= 1'b0;
						shift_reg <= {din_reg, shift_reg[8:1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						state_reg <= ST_LOW;
					end
				end
				ST_LOW:
				begin
					if (half_hit)
					begin
						if (last_bit & ~continuous_receive_enable_reg)
						begin
							state_reg <= ST_IDLE;
							sclk_reg <= 1'b0;
						end
						else
						begin
							state_reg <= ST_HIGH;
							sclk_reg <= 1'b1;
						end
						if (last_bit)
							bit_cnt_reg <= 4'h0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	sequence seq_word_end;
		word_done;
	endsequence

	sequence seq_next_high;
		##1 (state_reg == ST_HIGH) && sclk_reg;
	endsequence

	chk_start_gate: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(sclk_reg) |-> $past(start_ok))
		else $error("serial clock started without a receive enable");

	chk_fall_sample: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == ST_HIGH && half_hit && start_ok) |=> $fell(sclk_reg) &&
		bit_cnt_reg == $past(bit_cnt_reg) + 4'h1)
		else $error("bit not taken at the falling clock edge");

	chk_single_stop: assert property (@(posedge clk_sys) disable iff (reset)
		seq_word_end and (!continuous_receive_enable_reg && !wr_now) |=> !single_receive_enable_reg && state_reg == ST_IDLE)
		else $error("single reception did not stop after one word");

	chk_cont_run: assert property (@(posedge clk_sys) disable iff (reset)
		seq_word_end and continuous_receive_enable_reg |-> seq_next_high)
		else $error("continuous reception did not go on");

	chk_both_prio: assert property (@(posedge clk_sys) disable iff (reset)
		seq_word_end and (continuous_receive_enable_reg && single_receive_enable_reg && !wr_now) |=> single_receive_enable_reg)
		else $error("single enable cleared while continuous was set");

	chk_word_len: assert property (@(posedge clk_sys) disable iff (reset)
		word_done |-> bit_cnt_reg == (rx9_reg ? 4'h9 : 4'h8))
		else $error("wrong number of bits in a word");

	chk_done_irq: assert property (@(posedge clk_sys) disable iff (reset)
		word_done |=> irq_stat_reg[0] && (irq == (irq_en_reg[0] | (irq_stat_reg[1] & irq_en_reg[1]))))
		else $error("completion did not set the flag or interrupt wrongly gated");

	chk_data_load: assert property (@(posedge clk_sys) disable iff (reset)
		word_done && !full_reg |=> full_reg && rx_data_reg == word_byte($past(rx9_reg), $past(shift_reg)))
		else $error("received byte not stored");

	chk_err_clear: assert property (@(posedge clk_sys) disable iff (reset)
		continuous_receive_enable_clear && !overrun_evt |=> !overrun_error_flag_reg)
		else $error("overrun not cleared with continuous enable");

	chk_reset_vals: assert property (@(posedge clk_sys)
		reset |=> !serial_port_enable_reg && !continuous_receive_enable_reg && !single_receive_enable_reg && baud_reg == 8'h00 &&
		rx_data_reg == 8'h00 && !clock_source_select_reg && !sync_reg && !irq)
		else $error("reset values wrong");
endmodule

// ### dv/sync_slave_model.sv
// serial slave transmitter model that feeds the receive data line
`timescale 1ns/1ps
module sync_slave_model
(
	input wire logic clk_sys,
	input wire logic sclk,
	input wire logic nine_bits,
	output logic data_line
);
	logic [8:0] word_q[$];
	logic [8:0] cur = 9'h000;
	logic sclk_d = 1'b0;
	int bit_n = 0;
	initial data_line = 1'b0;
	task automatic push(input logic [8:0] w);
		word_q.push_back(w);
	endtask
	task automatic restart();
		bit_n = 0;
		word_q.delete();
	endtask
	always @(posedge clk_sys)
	begin
		sclk_d <= sclk;
		if (sclk && !sclk_d)
		begin
			if (bit_n == 0)
				cur = (word_q.size() > 0) ? word_q.pop_front() : 9'h000;
			data_line <= cur[bit_n];
			bit_n = (bit_n == (nine_bits ? 8 : 7)) ? 0 : bit_n + 1;
		end
		// hold spent after the fall: show the inverse, never the stale bit
		else if (!sclk && sclk_d)
			data_line <= ~data_line;
	end
endmodule

// ### dv/usart_sync_master_receive_bench.sv
// self-checking bench for the synchronous master receiver
`timescale 1ns/1ps
`include "usart_rx_map.svh"
module usart_sync_master_receive_bench
	import usart_rx_pkg::*;
;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, sclk_out, sclk_oe_n, data_out, data_oe_n, irq, data_in;
	logic sclk_pin;
	logic nine = 1'b0;
	logic [31:0] rv;
	logic [8:0] w;
	logic [7:0] b;
	byte_t exp_q[$];
	int n_fail = 0;
	int checked = 0;
	// the clock pin is pulled low while nobody drives it
	assign sclk_pin = sclk_oe_n ? 1'b0 : sclk_out;
	initial forever #2.5 clk_sys = ~clk_sys;
	usart_sync_master_receive u_dut
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hreadyout),
		.hwdata(hwdata),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n),
		.sclk_in(sclk_pin),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe_n(data_oe_n),
		.irq(irq)
	);
	sync_slave_model u_slave
	(
		.clk_sys(clk_sys),
		.sclk(sclk_pin),
		.nine_bits(nine),
		.data_line(data_in)
	);
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 40);
		rv = hrdata;
		if (hreadyout !== 1'b1)
			n_fail++;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rv, exp);
	endtask
	// pins are looked at mid-cycle, once the edge's updates have landed
	task automatic pins(input logic [31:0] exp);
		@(negedge clk_sys);
		check({29'h0, irq, sclk_out, sclk_oe_n}, exp);
		@(posedge clk_sys);
	endtask
	task automatic poll(input logic [31:0] m);
		int n;
		n = 0;
		do bus(1'b0, `OFS_IRQ_STATUS, 32'h0); while ((rv & m) !== m && ++n < 2000);
		if ((rv & m) !== m)
		begin
			n_fail++;
			$display("Error at %0t: status poll timed out", $time);
		end
	endtask
	task automatic send(input int cnt);
		repeat (cnt)
		begin
			w = 9'($urandom);
			u_slave.push(w);
			exp_q.push_back(w[7:0]);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		close_out();
	end
	initial
	begin
		void'($urandom(12515));
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(`OFS_RX_STATUS, 32'h00);
		rd(`OFS_RX_DATA, 32'h00);
		rd(`OFS_TX_STATUS, 32'h02);
		rd(`OFS_BAUD_DIV, 32'h00);
		rd(`OFS_IRQ_STATUS, 32'h00);
		rd(8'h1C, 32'h00);
		$display("test reset done");
		b = 8'($urandom);
		bus(1'b1, `OFS_BAUD_DIV, {24'h0, b});
		rd(`OFS_BAUD_DIV, {24'h0, b});
		bus(1'b1, `OFS_TX_STATUS, 32'hFF);
		rd(`OFS_TX_STATUS, 32'hF7);
		bus(1'b1, `OFS_RX_STATUS, 32'hC8);
		rd(`OFS_RX_STATUS, 32'hC0);
		bus(1'b1, `OFS_RX_DATA, 32'hFF);
		rd(`OFS_RX_DATA, 32'h00);
		repeat (40) @(posedge clk_sys);
		pins(32'h0);
		bus(1'b1, `OFS_TX_STATUS, 32'h80);
		bus(1'b1, `OFS_RX_STATUS, 32'hA0);
		repeat (40) @(posedge clk_sys);
		pins(32'h1);
		$display("test registers done");
		bus(1'b1, `OFS_RX_STATUS, 32'h00);
		bus(1'b1, `OFS_BAUD_DIV, 32'h03);
		bus(1'b1, `OFS_TX_STATUS, 32'h90);
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h3);
		send(1);
		bus(1'b1, `OFS_RX_STATUS, 32'hA0);
		poll(32'h1);
		pins(32'h4);
		rd(`OFS_RX_STATUS, 32'h80);
		rd(`OFS_RX_DATA, {24'h0, exp_q.pop_front()});
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h0);
		pins(32'h0);
		bus(1'b1, `OFS_IRQ_CLEAR, 32'h1);
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h3);
		repeat (300) @(posedge clk_sys);
		rd(`OFS_IRQ_STATUS, 32'h0);
		$display("test single done");
		nine = 1'b1;
		send(1);
		bus(1'b1, `OFS_RX_STATUS, 32'hE0);
		poll(32'h1);
		rd(`OFS_RX_STATUS, {24'h0, 7'h60, w[8]});
		rd(`OFS_RX_DATA, {24'h0, exp_q.pop_front()});
		bus(1'b1, `OFS_RX_STATUS, 32'h80);
		nine = 1'b0;
		$display("test nine bit done");
		send(3);
		bus(1'b1, `OFS_IRQ_CLEAR, 32'h3);
		bus(1'b1, `OFS_RX_STATUS, 32'hB0);
		repeat (3)
		begin
			poll(32'h1);
			bus(1'b1, `OFS_IRQ_CLEAR, 32'h1);
			rd(`OFS_RX_STATUS, 32'hB0);
			rd(`OFS_RX_DATA, {24'h0, exp_q.pop_front()});
		end
		bus(1'b1, `OFS_RX_STATUS, 32'h80);
		u_slave.restart();
		$display("test continuous done");
		send(2);
		bus(1'b1, `OFS_RX_STATUS, 32'h90);
		poll(32'h2);
		rd(`OFS_RX_STATUS, 32'h92);
		rd(`OFS_RX_DATA, {24'h0, exp_q.pop_front()});
		void'(exp_q.pop_front());
		bus(1'b1, `OFS_RX_STATUS, 32'h80);
		rd(`OFS_RX_STATUS, 32'h80);
		bus(1'b1, `OFS_IRQ_CLEAR, 32'h3);
		pins(32'h0);
		$display("test overrun done");
		close_out();
	end
endmodule
